/* tir_regs.sv */
/*
 * Type identifier and chip address register bank of a serial EEPROM.
 * Decodes device select, two address bytes and data bytes delivered as
 * byte events, answers each received byte with acknowledge or not, and
 * serves the read byte when the framing layer asks for one.
 * Assumes a framing layer that detects start and stop, shifts bytes,
 * drives the acknowledge slot from ack and sends tx_byte on request.
 */
`timescale 1ns/100ps
`default_nettype none

// Contract
// RULE_01 - The controller puts the type code held in the identifier register into every select.
// RULE_02 - The identifier register is eight bits, never writable, with its lock bit held at one.
// RULE_03 - The upper four identifier bits are the type field matched in the select byte.
// RULE_04 - Bits three to one of the identifier register always read as zero.
// RULE_05 - The identifier is read by random read with top address bits 111, the rest ignored.
// RULE_06 - After power-up the stored identifier bits are reloaded before any access is answered.
// RULE_07 - The chip address register holds the enable bits in three to one, lock in zero, upper zero.
// RULE_08 - The chip address register is read and written with top address bits 110, rest ignored.
// RULE_09 - Only select bytes whose chip enable field equals the stored enable bits are answered.
// RULE_10 - Chip address updates are taken only while its lock bit is zero.
// RULE_11 - A chip address write with more than one data byte is aborted with no change.
// RULE_12 - With the inhibit pin high or the lock set, the data byte is refused and no cycle starts.
// RULE_13 - Address bits and lock may change in one write; once locked, all four bits stay fixed.
// RULE_14 - After power-up and after each write cycle the register is reloaded from storage.
// RULE_15 - The chip address register ships as zero, or preset and locked in preset variants.
// RULE_16 - The inhibit pin high blocks writes: select and address acknowledged, data not.
// RULE_17 - A good write starts an internal write cycle during which the bank answers nothing.
module tir_regs #(
	parameter int WRITE_CYCLES = tir_pkg::WRITE_CYCLES,
	parameter logic [3:0] TYPE_CODE = tir_pkg::TYPE_CODE_DEFAULT,
	parameter logic [7:0] CHIP_ADDR_INIT = tir_pkg::CHIP_ADDR_FACTORY
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire tir_pkg::tir_bus_t bus_i,
	input wire logic write_inhibit_pin_i,
	output tir_pkg::tir_resp_t resp_o,
	output logic [2:0] chip_enable_addr_o
);

	tir_pkg::tir_state_t state_q;
	tir_pkg::tir_state_t state_d;
	logic ptr_q;
	logic ptr_d;
	logic [7:0] type_q;
	logic [7:0] type_d;
	logic [7:0] cda_q;
	logic [7:0] cda_d;
	logic [7:0] wdata_q;
	logic [7:0] wdata_d;
	logic pend_q;
	logic pend_d;
	logic abort_q;
	logic abort_d;
	tir_pkg::tir_resp_t resp_q;
	tir_pkg::tir_resp_t resp_d;
	logic rd_idx;
	logic [7:0] rd_data;
	logic nv_wr;
	logic wr_start;
	logic wr_done;
	logic [7:0] rx;

	// Identifier as read: reserved bits zero, lock bit forced to one.
	function automatic logic [7:0] type_view(input logic [7:0] raw);
		type_view = {raw[7:4], tir_pkg::TYPE_RSVD_ZERO, tir_pkg::TYPE_LOCK_SET};
	endfunction

	// Chip address as read: only the low nibble is kept, the rest reads zero.
	function automatic logic [7:0] cda_view(input logic [7:0] raw);
		cda_view = {tir_pkg::UPPER_ZERO, raw[tir_pkg::CDA_USED_MSB:0]};
	endfunction

	assign rx = bus_i.rx_byte;

	tir_nv_store #(
		.TYPE_INIT({TYPE_CODE, tir_pkg::TYPE_RSVD_ZERO, tir_pkg::TYPE_LOCK_SET}),
		.ADDR_INIT(CHIP_ADDR_INIT) // see RULE_15
	) u_store (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_en_i(nv_wr),
		.wr_data_i(wdata_q),
		.rd_idx_i(rd_idx),
		.rd_data_o(rd_data)
	);

	tir_wr_timer #(
		.CYCLES(WRITE_CYCLES)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(wr_start),
		.done_o(wr_done)
	);

	// The storage is committed when the cycle ends, so a reset in mid-cycle
	// drops the new byte; rst_i also reloads the factory value into storage.
	assign nv_wr = (state_q == tir_pkg::ST_BUSY) && wr_done; // see RULE_17
	assign rd_idx = (state_q == tir_pkg::ST_LOAD0) ? tir_pkg::IDX_TYPE_ID : tir_pkg::IDX_CHIP_ADDR;
	assign chip_enable_addr_o = cda_q[tir_pkg::CDA_CE_MSB:tir_pkg::CDA_CE_LSB];
	assign resp_o = resp_q;

	// Sequencer: reload, then select, address, data or read phases.
	always_comb begin
		state_d = state_q;
		ptr_d = ptr_q;
		type_d = type_q;
		cda_d = cda_q;
		wdata_d = wdata_q;
		pend_d = pend_q;
		abort_d = abort_q;
		wr_start = 1'b0;
		resp_d = resp_q;
		resp_d.ack_valid = 1'b0;
		resp_d.ack = 1'b0;
		resp_d.tx_valid = 1'b0;
		resp_d.busy = (state_q == tir_pkg::ST_BUSY);
		case (state_q)
			// Storage is read back word by word before anything is answered.
			tir_pkg::ST_LOAD0: begin
				state_d = tir_pkg::ST_LOAD1; // see RULE_06
			end
			tir_pkg::ST_LOAD1: begin
				type_d = rd_data; // see RULE_06
				state_d = tir_pkg::ST_LOAD2;
			end
			tir_pkg::ST_LOAD2: begin
				cda_d = rd_data; // see RULE_14
				state_d = tir_pkg::ST_IDLE;
			end
			// The write cycle hides the bank from the bus until it ends.
			tir_pkg::ST_BUSY: begin
				if (wr_done) begin
					state_d = tir_pkg::ST_LOAD0; // see RULE_14
				end
			end
			default: begin
				if (bus_i.start) begin
					state_d = tir_pkg::ST_DSEL;
					pend_d = 1'b0;
					abort_d = 1'b0;
				end else if (bus_i.stop) begin
					state_d = tir_pkg::ST_IDLE;
					pend_d = 1'b0;
					if (state_q == tir_pkg::ST_DATA && pend_q && !abort_q) begin
						state_d = tir_pkg::ST_BUSY; // see RULE_17
						wr_start = 1'b1;
					end
				end else if (bus_i.tx_req && state_q == tir_pkg::ST_READ) begin
					resp_d.tx_valid = 1'b1;
					if (ptr_q == tir_pkg::IDX_TYPE_ID) begin
						resp_d.tx_byte = type_view(type_q); // see RULE_02, RULE_04
					end else begin
						resp_d.tx_byte = cda_view(cda_q); // see RULE_07
					end
				end else if (bus_i.rx_valid) begin
					case (state_q)
						tir_pkg::ST_DSEL: begin
							// Type field and chip enable field must both match.
							if (rx[tir_pkg::DSEL_TYPE_MSB:tir_pkg::DSEL_TYPE_LSB] == type_q[7:4]
							    && rx[tir_pkg::DSEL_CE_MSB:tir_pkg::DSEL_CE_LSB]
							    == cda_q[tir_pkg::CDA_CE_MSB:tir_pkg::CDA_CE_LSB]) begin // see RULE_03, RULE_09
								resp_d.ack_valid = 1'b1;
								resp_d.ack = 1'b1;
								state_d = rx[tir_pkg::DSEL_RW_BIT] ? tir_pkg::ST_READ : tir_pkg::ST_AHI;
							end else begin
								state_d = tir_pkg::ST_IGNORE;
							end
						end
						tir_pkg::ST_AHI: begin
							// Only the top three bits pick the register; the rest are ignored.
							if (rx[tir_pkg::AHI_SEL_MSB:tir_pkg::AHI_SEL_LSB] == tir_pkg::SEL_TYPE_ID) begin
								ptr_d = tir_pkg::IDX_TYPE_ID; // see RULE_05
								resp_d.ack_valid = 1'b1;
								resp_d.ack = 1'b1;
								state_d = tir_pkg::ST_ALO;
							end else if (rx[tir_pkg::AHI_SEL_MSB:tir_pkg::AHI_SEL_LSB]
							             == tir_pkg::SEL_CHIP_ADDR) begin
								ptr_d = tir_pkg::IDX_CHIP_ADDR; // see RULE_08
								resp_d.ack_valid = 1'b1;
								resp_d.ack = 1'b1;
								state_d = tir_pkg::ST_ALO;
							end else begin
								state_d = tir_pkg::ST_IGNORE;
							end
						end
						tir_pkg::ST_ALO: begin
							// Low address byte is a don't care but is acknowledged.
							resp_d.ack_valid = 1'b1; // see RULE_16
							resp_d.ack = 1'b1;
							state_d = tir_pkg::ST_DATA;
						end
						tir_pkg::ST_DATA: begin
							resp_d.ack_valid = 1'b1;
							if (ptr_q == tir_pkg::IDX_TYPE_ID) begin
								resp_d.ack = 1'b0; // see RULE_02
							end else if (write_inhibit_pin_i || cda_q[tir_pkg::REG_LOCK_BIT]) begin
								resp_d.ack = 1'b0; // see RULE_10, RULE_12, RULE_16
								pend_d = 1'b0;
							end else if (pend_q || abort_q) begin
								// A second byte kills the write; the register keeps its value.
								resp_d.ack = 1'b0; // see RULE_11
								pend_d = 1'b0;
								abort_d = 1'b1;
							end else begin
								// Address and lock bits are taken together in one write.
								wdata_d = cda_view(rx); // see RULE_13
								resp_d.ack = 1'b1;
								pend_d = 1'b1;
							end
						end
						default: begin
							state_d = state_q;
						end
					endcase
				end
			end
		endcase
	end

	// Power-on reset empties the shadows and forces a reload from storage.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= tir_pkg::ST_LOAD0; // see RULE_06, RULE_14
			ptr_q <= tir_pkg::IDX_TYPE_ID;
			type_q <= 8'h00;
			cda_q <= 8'h00;
			wdata_q <= 8'h00;
			pend_q <= 1'b0;
			abort_q <= 1'b0;
			resp_q <= '0;
		end else begin
			state_q <= state_d;
			ptr_q <= ptr_d;
			type_q <= type_d;
			cda_q <= cda_d;
			wdata_q <= wdata_d;
			pend_q <= pend_d;
			abort_q <= abort_d;
			resp_q <= resp_d;
		end
	end

endmodule

`default_nettype wire

/* tir_pkg.sv */
/*
 * Package for the type identifier and chip address register bank.
 * Holds the byte-level bus carriers, the sequencer states, field positions,
 * register indices, factory values and the internal write cycle timing.
 * Assumes a framing layer outside the bank that turns the serial bus into
 * byte events on the 125 MHz system clock.
 */
package tir_pkg;

	// Clock rate and the internal non-volatile write cycle time.
	localparam int CLK_MHZ = 125;
	localparam int WRITE_TIME_US = 4000;
	localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;

	// Device select byte layout.
	localparam int DSEL_TYPE_MSB = 7;
	localparam int DSEL_TYPE_LSB = 4;
	localparam int DSEL_CE_MSB = 3;
	localparam int DSEL_CE_LSB = 1;
	localparam int DSEL_RW_BIT = 0;

	// Register selector in the first address byte.
	localparam int AHI_SEL_MSB = 7;
	localparam int AHI_SEL_LSB = 5;
	localparam logic [2:0] SEL_TYPE_ID = 3'h7;
	localparam logic [2:0] SEL_CHIP_ADDR = 3'h6;

	// Register field positions.
	localparam int REG_LOCK_BIT = 0;
	localparam int CDA_CE_MSB = 3;
	localparam int CDA_CE_LSB = 1;
	localparam int CDA_USED_MSB = 3;

	// Storage word indices.
	localparam logic IDX_TYPE_ID = 1'h0;
	localparam logic IDX_CHIP_ADDR = 1'h1;

	// Factory values; the type code below is arbitrary, not a real part's.
	localparam logic [3:0] TYPE_CODE_DEFAULT = 4'hA;
	localparam logic [7:0] CHIP_ADDR_FACTORY = 8'h00;
	localparam logic [3:0] UPPER_ZERO = 4'h0;
	localparam logic [2:0] TYPE_RSVD_ZERO = 3'h0;
	localparam logic TYPE_LOCK_SET = 1'h1;

	// Byte events from the framing layer.
	typedef struct packed {
		logic start;
		logic stop;
		logic rx_valid;
		logic [7:0] rx_byte;
		logic tx_req;
	} tir_bus_t;

	// Answers to the framing layer.
	typedef struct packed {
		logic ack_valid;
		logic ack;
		logic tx_valid;
		logic [7:0] tx_byte;
		logic busy;
	} tir_resp_t;

	typedef enum logic [3:0] {
		ST_LOAD0 = 4'h0,
		ST_LOAD1 = 4'h1,
		ST_LOAD2 = 4'h2,
		ST_IDLE = 4'h3,
		ST_DSEL = 4'h4,
		ST_AHI = 4'h5,
		ST_ALO = 4'h6,
		ST_DATA = 4'h7,
		ST_READ = 4'h8,
		ST_IGNORE = 4'h9,
		ST_BUSY = 4'hA
	} tir_state_t;

endpackage

/* tir_nv_store.sv */
/*
 * Two-word storage standing in for the non-volatile cells of the bank.
 * Read data come out of a register one cycle after the index is given.
 * Assumes rst_i models factory programming: it loads the delivery values.
 */
`timescale 1ns/100ps
`default_nettype none

module tir_nv_store #(
	parameter logic [7:0] TYPE_INIT = 8'h00,
	parameter logic [7:0] ADDR_INIT = 8'h00
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wr_en_i,
	input wire logic [7:0] wr_data_i,
	input wire logic rd_idx_i,
	output logic [7:0] rd_data_o
);

	logic [7:0] type_q;
	logic [7:0] type_d;
	logic [7:0] addr_q;
	logic [7:0] addr_d;
	logic [7:0] rd_q;
	logic [7:0] rd_d;

	// Only the chip address word has a write port; the type word is frozen.
	always_comb begin
		type_d = type_q;
		addr_d = wr_en_i ? wr_data_i : addr_q;
		rd_d = (rd_idx_i == tir_pkg::IDX_TYPE_ID) ? type_q : addr_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			type_q <= TYPE_INIT;
			addr_q <= ADDR_INIT;
			rd_q <= 8'h00;
		end else begin
			type_q <= type_d;
			addr_q <= addr_d;
			rd_q <= rd_d;
		end
	end

	assign rd_data_o = rd_q;

endmodule

`default_nettype wire

/* tir_wr_timer.sv */
/*
 * Down counter that times the internal write cycle.
 * Assumes start_i is a one-cycle pulse; done_o pulses once when time is up.
 */
`timescale 1ns/100ps
`default_nettype none

module tir_wr_timer #(
	parameter int CYCLES = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	output logic done_o
);

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic done_q;
	logic done_d;

	// Counts down to one and pulses done; a zero count means idle.
	always_comb begin
		cnt_d = cnt_q;
		done_d = 1'b0;
		if (start_i) begin
			cnt_d = 32'(CYCLES);
		end else if (cnt_q == 32'h1) begin
			cnt_d = 32'h0;
			done_d = 1'b1;
		end else if (cnt_q != 32'h0) begin
			cnt_d = cnt_q - 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 32'h0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			done_q <= done_d;
		end
	end

	assign done_o = done_q;

endmodule

`default_nettype wire

/* tir_regs_sva.sv */
/*
 * Checker for the type identifier and chip address register bank.
 * Assumes only the ports of tir_regs and a short write cycle parameter.
 */
`timescale 1ns/100ps
`default_nettype none

module tir_regs_chk #(
	parameter int WRITE_CYCLES = 8,
	parameter logic [3:0] TYPE_CODE = 4'hA,
	parameter logic [7:0] CHIP_ADDR_INIT = 8'h00
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire tir_pkg::tir_bus_t bus_i,
	input wire logic write_inhibit_pin_i,
	input wire tir_pkg::tir_resp_t resp_o,
	input wire logic [2:0] chip_enable_addr_o
);
	// All checks share the one clock and its reset.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_ack_lat;
		resp_o.ack_valid |-> $past(bus_i.rx_valid);
	endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("answer without a byte");

	property p_tx_lat;
		resp_o.tx_valid |-> $past(bus_i.tx_req);
	endproperty
	a_tx_lat: assert property (p_tx_lat) else $error("read byte without request");

	// A read byte is either the identifier or the chip address register.
	property p_tx_fields;
		resp_o.tx_valid |-> (resp_o.tx_byte == {TYPE_CODE, 4'h1})
			|| (resp_o.tx_byte[7:4] == 4'h0 && resp_o.tx_byte[3:1] == chip_enable_addr_o);
	endproperty
	a_tx_fields: assert property (p_tx_fields) else $error("read byte fields wrong");

	property p_busy_quiet;
		resp_o.busy |-> !resp_o.ack_valid && !resp_o.tx_valid;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("answer during write cycle");

	property p_busy_len;
		$rose(resp_o.busy) |-> resp_o.busy [*8];
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("write cycle too short");

	property p_busy_fall;
		$rose(resp_o.busy) |-> ##[1:40] !resp_o.busy;
	endproperty
	a_busy_fall: assert property (p_busy_fall) else $error("write cycle never ends");

	property p_busy_rise;
		$rose(resp_o.busy) |-> $past(bus_i.stop, 2) && !$past(write_inhibit_pin_i, 2);
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("write cycle without stop");

	property p_nack_idle;
		resp_o.ack_valid && !resp_o.ack |-> ##1 (!resp_o.busy) [*4];
	endproperty
	a_nack_idle: assert property (p_nack_idle) else $error("refused write started");

	// The enable bits move only in the reload that ends two cycles after busy
	// falls, or in the reload after reset, never on bare traffic.
	property p_ce_hold;
		$changed(chip_enable_addr_o) |-> $past(resp_o.busy, 3) || $past(rst_i, 4);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("enable bits changed");
endmodule

bind tir_regs tir_regs_chk #(
	.WRITE_CYCLES(WRITE_CYCLES),
	.TYPE_CODE(TYPE_CODE),
	.CHIP_ADDR_INIT(CHIP_ADDR_INIT)
) u_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.bus_i(bus_i),
	.write_inhibit_pin_i(write_inhibit_pin_i),
	.resp_o(resp_o),
	.chip_enable_addr_o(chip_enable_addr_o)
);

`default_nettype wire

/* tir_ctrl_model.sv */
/*
 * Bus controller model that issues byte events to the register bank.
 * Assumes the bank answers one cycle after each event, as its contract says.
 */
`timescale 1ns/100ps
`default_nettype none

module tir_ctrl_model #(
	parameter logic [3:0] TYPE_CODE = 4'hA
) (
	input wire logic clk_i,
	input wire tir_pkg::tir_resp_t resp_i,
	output var tir_pkg::tir_bus_t bus_o
);
	logic got_v;
	logic got_ack;
	logic [7:0] got_byte;

	initial bus_o = '0;

	// One event pulse; the idle byte is inverted so stale data never matches.
	task ev(input logic [3:0] k, input logic [7:0] b);
		@(posedge clk_i);
		bus_o <= {k[3], k[2], k[1], b, k[0]};
		@(posedge clk_i);
		bus_o <= {3'h0, ~b, 1'b0};
		#1;
		got_v = resp_i.ack_valid | resp_i.tx_valid;
		got_ack = resp_i.ack;
		got_byte = resp_i.tx_byte;
	endtask

	task sel(input logic [2:0] ce, input logic rw);
		ev(4'h2, {TYPE_CODE, ce, rw});
	endtask

	// Low address bits are set on purpose, the bank must ignore them.
	task addr(input logic [2:0] s3);
		ev(4'h2, {s3, 5'h15});
		ev(4'h2, 8'hA5);
	endtask
endmodule

`default_nettype wire

/* tb.sv */
/*
 * Self-checking testbench for the register bank.
 * Assumes the controller model and the checker bound to tir_regs.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch %s expected %0h seen %0h", n, e, g); end end

module tb;
	localparam logic [3:0] TC = 4'hA;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic inhibit = 1'b0;
	tir_pkg::tir_bus_t bus;
	tir_pkg::tir_resp_t resp;
	logic [2:0] ce_addr;
	int mismatches = 0;
	int comparisons = 0;

	always #4 clk_i = ~clk_i;

	tir_ctrl_model #(.TYPE_CODE(TC)) u_ctrl (.clk_i(clk_i), .resp_i(resp), .bus_o(bus));

	tir_regs #(.WRITE_CYCLES(8), .TYPE_CODE(TC), .CHIP_ADDR_INIT(8'h00)) u_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.bus_i(bus),
		.write_inhibit_pin_i(inhibit),
		.resp_o(resp),
		.chip_enable_addr_o(ce_addr)
	);

	task summarize();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Write n data bytes; a good write must raise busy and drop it in time.
	task wr(input logic [2:0] ce, input logic [2:0] s3, input logic [7:0] d, input int n,
		input logic ok);
		int i;
		logic seen;
		seen = 1'b0;
		u_ctrl.ev(4'h8, 8'h00);
		u_ctrl.sel(ce, 1'b0);
		`CHK("select ack", 1'b1, u_ctrl.got_ack)
		u_ctrl.addr(s3);
		`CHK("address ack", 1'b1, u_ctrl.got_ack)
		for (i = 0; i < n; i++) begin
			u_ctrl.ev(4'h2, d);
		end
		`CHK("data ack", ok, u_ctrl.got_ack & u_ctrl.got_v)
		u_ctrl.ev(4'h4, 8'h00);
		// A refused write is watched for a while too, so a stray busy is caught.
		for (i = 0; i < (ok ? 64 : 12); i++) begin
			@(posedge clk_i);
			#1;
			seen = seen | resp.busy;
			if (seen && !resp.busy) begin
				break;
			end
		end
		if (ok && i == 64) begin
			mismatches++;
			summarize();
		end
		`CHK("write cycle", ok, seen)
		// Busy drops before the shadow reload ends, and events in those cycles are lost.
		repeat (3) @(posedge clk_i);
		#1;
	endtask

	task rdchk(input logic [2:0] ce, input logic [2:0] s3, input logic [7:0] e);
		u_ctrl.ev(4'h8, 8'h00);
		u_ctrl.sel(ce, 1'b0);
		u_ctrl.addr(s3);
		u_ctrl.ev(4'h8, 8'h00);
		u_ctrl.sel(ce, 1'b1);
		u_ctrl.ev(4'h1, 8'h00);
		`CHK("read byte", e, u_ctrl.got_v ? u_ctrl.got_byte : 8'hXX)
		u_ctrl.ev(4'h4, 8'h00);
	endtask

	// Main sequence: factory state, refusals, then a write and a lock.
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rdchk(3'h0, 3'h7, {TC, 4'h1});
		rdchk(3'h0, 3'h6, 8'h00);
		$display("test factory done");
		wr(3'h0, 3'h7, 8'h50, 1, 1'b0);
		@(posedge clk_i) inhibit <= 1'b1;
		wr(3'h0, 3'h6, 8'h0A, 1, 1'b0);
		@(posedge clk_i) inhibit <= 1'b0;
		wr(3'h0, 3'h6, 8'h0A, 2, 1'b0);
		rdchk(3'h0, 3'h6, 8'h00);
		u_ctrl.ev(4'h8, 8'h00);
		u_ctrl.ev(4'h2, {~TC, 4'h0});
		`CHK("foreign type", 1'b0, u_ctrl.got_v)
		u_ctrl.ev(4'h4, 8'h00);
		$display("test refusals done");
		wr(3'h0, 3'h6, 8'hFA, 1, 1'b1);
		`CHK("chip enable", 3'h5, ce_addr)
		u_ctrl.ev(4'h8, 8'h00);
		u_ctrl.sel(3'h0, 1'b0);
		`CHK("old address", 1'b0, u_ctrl.got_v)
		u_ctrl.ev(4'h4, 8'h00);
		rdchk(3'h5, 3'h6, 8'h0A);
		wr(3'h5, 3'h6, 8'h07, 1, 1'b1);
		wr(3'h3, 3'h6, 8'h02, 1, 1'b0);
		rdchk(3'h3, 3'h6, 8'h07);
		$display("test address lock done");
		summarize();
	end
endmodule

`default_nettype wire
